/* File: core/audio_regs_defs.vh */
// Register offsets, field positions, reset values and timing for the audio control bank
`ifndef AUDIO_REGS_DEFS_VH
`define AUDIO_REGS_DEFS_VH

`define ADDR_AUDIO_SUBSYSTEM_CONTROL      16'hA038
`define ADDR_PRIMARY_DAC_LEFT_VOLUME      16'hA1A0
`define ADDR_PRIMARY_DAC_RIGHT_VOLUME     16'hA1A1
`define ADDR_SECOND_DAC_LEFT_VOLUME       16'hA1A2
`define ADDR_SECOND_DAC_RIGHT_VOLUME      16'hA1A3
`define ADDR_MIXER_OUT_LEFT_VOLUME        16'hA1A6
`define ADDR_MIXER_OUT_RIGHT_VOLUME       16'hA1A7
`define ADDR_PRIMARY_DAC_LEFT_MIXER_GAIN  16'hA1A8
`define ADDR_PRIMARY_DAC_RIGHT_MIXER_GAIN 16'hA1A9

`define CTRL_RESET_BIT        0
`define CTRL_POWER_ON_BIT     1
`define CTRL_DIGITAL_OFF_BIT  2
`define CTRL_AMP_OFF_BIT      3

`define MUTE_BIT              7

`define RST_CONTROL           8'h00
`define RST_DAC_VOLUME        8'h80
`define RST_MIXER_OUT_VOLUME  8'h80
`define RST_MIXER_GAIN        8'h8C

`define MASK_MIXER_FIELDS     8'h9F

`define CLK_PERIOD_NS         40
`define SUBSYS_RESET_NS       250
// Rounded up so the pulse is never shorter than the required width
`define SUBSYS_RESET_CYCLES   ((`SUBSYS_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: core/vol_reg.v */
// One 8-bit read/write control register with a reset value
`timescale 1ns/10ps
module vol_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input  wire       mclk,    // System clock
  input  wire       resetn,  // Async reset, active low
  input  wire       load,    // Write strobe for this register
  input  wire [7:0] wdata,   // Write data
  output reg  [7:0] value    // Stored value
);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      value <= RESET_VALUE;
    end else if (load) begin
      value <= wdata;
    end
  end
endmodule // vol_reg

/* File: core/pulse_timer.v */
// Self-clearing pulse: set by a request, cleared after a fixed cycle count
`timescale 1ns/10ps
module pulse_timer #(
  parameter       CYCLES = 6,
  parameter       CW     = 4
) (
  input  wire mclk,    // System clock
  input  wire resetn,  // Async reset, active low
  input  wire start,   // One-cycle request to (re)start the pulse
  output reg  active   // High while the pulse runs
);
  localparam [CW-1:0] LAST = CYCLES[CW-1:0] - 1'b1;
  reg [CW-1:0] count;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
      count  <= {CW{1'b0}};
    end else if (start) begin
      active <= 1'b1;
      count  <= {CW{1'b0}};
    end else if (active) begin
      if (count == LAST) begin
        active <= 1'b0;
      end
      count <= count + 1'b1;
    end
  end
endmodule // pulse_timer

/* File: core/audio_control_volume_regs.v */
// Audio subsystem control and volume register bank
// What this block does
// - Host configures audio through 8-bit words written to addressed registers.
// - Writing one to bit 0 resets audio; bit self-clears after 7 cycles (280 ns).
// - Bit 1 zero keeps audio in low power; one enables; resets zero.
// - Bit 2 set turns off digital audio section; resets zero.
// - Bit 3 set turns off digital Class-D section; resets zero.
// - DAC volume bits 6..0 give attenuation in 0.75 dB steps.
// - DAC volume bit 7 mutes the channel; resets to one.
// - DAC attenuation resets to zero; four channels have separate registers.
// - Mixer output bits 4..0 give attenuation in 1.5 dB steps; reset zero.
// - Mixer output bits 6..5 reserved zero (here stored and read back as written); bit 7 mutes, resets one.
// - DAC0 mixer-input gain is 5 bits, resets to 0Ch meaning 0 dB.
// - DAC0 mixer-input bit 7 mutes that input, resets one; 6..5 reserved.
`timescale 1ns/10ps
`include "audio_regs_defs.vh"
module audio_control_volume_regs (
  input  wire        mclk,                 // System clock, 25 MHz
  input  wire        resetn,               // Async reset, active low
  input  wire [15:0] reg_addr,             // Register address
  input  wire        reg_write,            // Write strobe, one cycle
  input  wire [7:0]  reg_wdata,            // Write data
  output reg  [7:0]  reg_rdata,            // Read data for reg_addr, registered
  output wire        subsystem_reset,      // Audio subsystem reset pulse, active high
  output wire        audio_power_on,       // Subsystem enabled; low means low power
  output wire        digital_path_off,     // Digital audio section off
  output wire        amp_digital_off,      // Digital Class-D section off
  output wire [6:0]  dac0_left_atten,      // Primary DAC left attenuation code
  output wire        dac0_left_mute,       // Primary DAC left mute
  output wire [6:0]  dac0_right_atten,     // Primary DAC right attenuation code
  output wire        dac0_right_mute,      // Primary DAC right mute
  output wire [6:0]  dac1_left_atten,      // Second DAC left attenuation code
  output wire        dac1_left_mute,       // Second DAC left mute
  output wire [6:0]  dac1_right_atten,     // Second DAC right attenuation code
  output wire        dac1_right_mute,      // Second DAC right mute
  output wire [4:0]  mix_left_atten,       // Mixer output left attenuation
  output wire        mix_left_mute,        // Mixer output left mute
  output wire [4:0]  mix_right_atten,      // Mixer output right attenuation
  output wire        mix_right_mute,       // Mixer output right mute
  output wire [4:0]  primary_left_mixer_gain,  // DAC0 left mixer-input gain code
  output wire        primary_left_mixer_mute,  // DAC0 left mixer-input mute
  output wire [4:0]  primary_right_mixer_gain, // DAC0 right mixer-input gain code
  output wire        primary_right_mixer_mute  // DAC0 right mixer-input mute
);

  // Pulse length rounded up to whole clock cycles
  localparam RESET_CYCLES = `SUBSYS_RESET_CYCLES;
  localparam RESET_CW     = 4;

  wire [7:0] control_q;
  wire [7:0] dac0l_q;
  wire [7:0] dac0r_q;
  wire [7:0] dac1l_q;
  wire [7:0] dac1r_q;
  wire [7:0] mixl_q;
  wire [7:0] mixr_q;
  wire [7:0] gainl_q;
  wire [7:0] gainr_q;
  wire       reset_active;

  // one-hot write select
  // A write to a reserved or unmapped address selects nothing and changes no state
  reg [8:0] wr_sel;
  always @* begin
    wr_sel = 9'h000;
    if (reg_write) begin
      case (reg_addr)
        `ADDR_AUDIO_SUBSYSTEM_CONTROL:      wr_sel = 9'h001;
        `ADDR_PRIMARY_DAC_LEFT_VOLUME:      wr_sel = 9'h002;
        `ADDR_PRIMARY_DAC_RIGHT_VOLUME:     wr_sel = 9'h004;
        `ADDR_SECOND_DAC_LEFT_VOLUME:       wr_sel = 9'h008;
        `ADDR_SECOND_DAC_RIGHT_VOLUME:      wr_sel = 9'h010;
        `ADDR_MIXER_OUT_LEFT_VOLUME:        wr_sel = 9'h020;
        `ADDR_MIXER_OUT_RIGHT_VOLUME:       wr_sel = 9'h040;
        `ADDR_PRIMARY_DAC_LEFT_MIXER_GAIN:  wr_sel = 9'h080;
        `ADDR_PRIMARY_DAC_RIGHT_MIXER_GAIN: wr_sel = 9'h100;
        default:                            wr_sel = 9'h000;
      endcase
    end
  end

  wire wr_ctrl  = wr_sel[0];
  wire wr_dac0l = wr_sel[1];
  wire wr_dac0r = wr_sel[2];
  wire wr_dac1l = wr_sel[3];
  wire wr_dac1r = wr_sel[4];
  wire wr_mixl  = wr_sel[5];
  wire wr_mixr  = wr_sel[6];
  wire wr_gainl = wr_sel[7];
  wire wr_gainr = wr_sel[8];

  localparam [7:0] CTRL_RST = `RST_CONTROL;
  reg              ctrl_power_on;
  reg              ctrl_digital_off;
  reg              ctrl_amp_off;
  reg        [3:0] ctrl_spare;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_power_on    <= CTRL_RST[`CTRL_POWER_ON_BIT];
      ctrl_digital_off <= CTRL_RST[`CTRL_DIGITAL_OFF_BIT];
      ctrl_amp_off     <= CTRL_RST[`CTRL_AMP_OFF_BIT];
      ctrl_spare       <= CTRL_RST[7:4];
    end else if (wr_ctrl) begin
      ctrl_power_on    <= reg_wdata[`CTRL_POWER_ON_BIT];
      ctrl_digital_off <= reg_wdata[`CTRL_DIGITAL_OFF_BIT];
      ctrl_amp_off     <= reg_wdata[`CTRL_AMP_OFF_BIT];
      ctrl_spare       <= reg_wdata[7:4];
    end
  end

  // Bit 0 is not stored; it reads back as the live pulse, so software sees it clear itself
  assign control_q = {ctrl_spare, ctrl_amp_off, ctrl_digital_off, ctrl_power_on, reset_active};

  // a zero write never starts it
  // Rewriting one while the pulse runs restarts the full count
  pulse_timer #(
    .CYCLES (RESET_CYCLES),
    .CW     (RESET_CW)
  ) u_reset_pulse (
    .mclk   (mclk),
    .resetn (resetn),
    .start  (wr_ctrl && reg_wdata[`CTRL_RESET_BIT]),
    .active (reset_active)
  );

  vol_reg #(.RESET_VALUE(`RST_DAC_VOLUME)) u_dac0l (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_dac0l),
    .wdata  (reg_wdata),
    .value  (dac0l_q)
  );

  vol_reg #(.RESET_VALUE(`RST_DAC_VOLUME)) u_dac0r (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_dac0r),
    .wdata  (reg_wdata),
    .value  (dac0r_q)
  );

  vol_reg #(.RESET_VALUE(`RST_DAC_VOLUME)) u_dac1l (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_dac1l),
    .wdata  (reg_wdata),
    .value  (dac1l_q)
  );

  vol_reg #(.RESET_VALUE(`RST_DAC_VOLUME)) u_dac1r (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_dac1r),
    .wdata  (reg_wdata),
    .value  (dac1r_q)
  );

  vol_reg #(.RESET_VALUE(`RST_MIXER_OUT_VOLUME)) u_mixl (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_mixl),
    .wdata  (reg_wdata),
    .value  (mixl_q)
  );

  vol_reg #(.RESET_VALUE(`RST_MIXER_OUT_VOLUME)) u_mixr (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_mixr),
    .wdata  (reg_wdata),
    .value  (mixr_q)
  );

  vol_reg #(.RESET_VALUE(`RST_MIXER_GAIN)) u_gainl (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_gainl),
    .wdata  (reg_wdata),
    .value  (gainl_q)
  );

  vol_reg #(.RESET_VALUE(`RST_MIXER_GAIN)) u_gainr (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (wr_gainr),
    .wdata  (reg_wdata),
    .value  (gainr_q)
  );

  assign subsystem_reset  = reset_active;
  assign audio_power_on   = control_q[`CTRL_POWER_ON_BIT];
  assign digital_path_off = control_q[`CTRL_DIGITAL_OFF_BIT];
  assign amp_digital_off  = control_q[`CTRL_AMP_OFF_BIT];

  // registers drive the path directly, so a write applies on the next cycle
  assign dac0_left_atten  = dac0l_q[6:0];
  assign dac0_left_mute   = dac0l_q[`MUTE_BIT];

  assign dac0_right_atten = dac0r_q[6:0];
  assign dac0_right_mute  = dac0r_q[`MUTE_BIT];

  assign dac1_left_atten  = dac1l_q[6:0];
  assign dac1_left_mute   = dac1l_q[`MUTE_BIT];

  assign dac1_right_atten = dac1r_q[6:0];
  assign dac1_right_mute  = dac1r_q[`MUTE_BIT];

  assign mix_left_atten   = mixl_q[4:0];
  assign mix_left_mute    = mixl_q[`MUTE_BIT];

  assign mix_right_atten  = mixr_q[4:0];
  assign mix_right_mute   = mixr_q[`MUTE_BIT];

  assign primary_left_mixer_gain  = gainl_q[4:0];
  assign primary_left_mixer_mute  = gainl_q[`MUTE_BIT];

  assign primary_right_mixer_gain = gainr_q[4:0];
  assign primary_right_mixer_mute = gainr_q[`MUTE_BIT];

  // readback of every mapped register
  // Read data registered one cycle after the address; unmapped reads return zero
  // Reserved bits read back exactly as written
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `ADDR_AUDIO_SUBSYSTEM_CONTROL:      next_rdata = control_q;
      `ADDR_PRIMARY_DAC_LEFT_VOLUME:      next_rdata = dac0l_q;
      `ADDR_PRIMARY_DAC_RIGHT_VOLUME:     next_rdata = dac0r_q;
      `ADDR_SECOND_DAC_LEFT_VOLUME:       next_rdata = dac1l_q;
      `ADDR_SECOND_DAC_RIGHT_VOLUME:      next_rdata = dac1r_q;
      `ADDR_MIXER_OUT_LEFT_VOLUME:        next_rdata = mixl_q;
      `ADDR_MIXER_OUT_RIGHT_VOLUME:       next_rdata = mixr_q;
      `ADDR_PRIMARY_DAC_LEFT_MIXER_GAIN:  next_rdata = gainl_q;
      `ADDR_PRIMARY_DAC_RIGHT_MIXER_GAIN: next_rdata = gainr_q;
      default:                            next_rdata = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // audio_control_volume_regs

/* File: test/audio_regs_props.sv */
// Concurrent checks on the ports of the audio control bank
`timescale 1ns/10ps
`include "audio_regs_defs.vh"
module audio_regs_props (
  input wire        mclk,                    // Clock
  input wire        resetn,                  // Reset, active low
  input wire [15:0] reg_addr,                // Address
  input wire        reg_write,               // Write strobe
  input wire [7:0]  reg_wdata,               // Write data
  input wire        subsystem_reset,         // Reset pulse
  input wire        audio_power_on,          // Enable
  input wire        digital_path_off,        // Digital audio off
  input wire        amp_digital_off,         // Amp digital off
  input wire [6:0]  dac0_left_atten,         // DAC0 left level
  input wire        dac0_left_mute,          // DAC0 left mute
  input wire [4:0]  mix_left_atten,          // Mixer left level
  input wire        mix_left_mute,           // Mixer left mute
  input wire [4:0]  primary_left_mixer_gain, // Mixer input gain
  input wire        primary_left_mixer_mute  // Mixer input mute
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire ctl_wr = reg_write && reg_addr == `ADDR_AUDIO_SUBSYSTEM_CONTROL;
  sequence set_req; ctl_wr && reg_wdata[0]; endsequence
  sequence pulse_run; subsystem_reset [*7]; endsequence
  a_pulse_len: assert property (set_req |=> pulse_run)
    else $error("reset pulse shorter than seven cycles");
  a_pulse_ends: assert property ((set_req ##1 (!ctl_wr) [*7]) |=> !subsystem_reset)
    else $error("reset pulse did not clear");
  a_no_spur: assert property ($rose(subsystem_reset) |-> $past(ctl_wr && reg_wdata[0]))
    else $error("reset pulse without request");
  a_zero_nop: assert property (ctl_wr && !reg_wdata[0] && !subsystem_reset |=> !subsystem_reset)
    else $error("writing zero started a pulse");
  a_ctl_bits: assert property (ctl_wr |=> {amp_digital_off, digital_path_off, audio_power_on} == $past(reg_wdata[3:1]))
    else $error("control outputs differ from write");
  a_ctl_hold: assert property (!ctl_wr |=> $stable(audio_power_on))
    else $error("enable changed without control write");
  a_dac_load: assert property (reg_write && reg_addr == `ADDR_PRIMARY_DAC_LEFT_VOLUME |=> {dac0_left_mute, dac0_left_atten} == $past(reg_wdata))
    else $error("dac volume not applied");
  a_mix_load: assert property (reg_write && reg_addr == `ADDR_MIXER_OUT_LEFT_VOLUME |=> {mix_left_mute, mix_left_atten} == {$past(reg_wdata[7]), $past(reg_wdata[4:0])})
    else $error("mixer volume not applied");
  a_gain_load: assert property (reg_write && reg_addr == `ADDR_PRIMARY_DAC_LEFT_MIXER_GAIN |=> {primary_left_mixer_mute, primary_left_mixer_gain} == {$past(reg_wdata[7]), $past(reg_wdata[4:0])})
    else $error("mixer gain not applied");
endmodule // audio_regs_props
bind audio_control_volume_regs audio_regs_props chk (.mclk, .resetn, .reg_addr, .reg_write, .reg_wdata, .subsystem_reset,
  .audio_power_on, .digital_path_off, .amp_digital_off, .dac0_left_atten, .dac0_left_mute, .mix_left_atten,
  .mix_left_mute, .primary_left_mixer_gain, .primary_left_mixer_mute);

/* File: test/audio_host_model.sv */
// Host side model issuing register writes and reads
`timescale 1ns/10ps
module audio_host_model (
  input  wire        mclk,              // Clock
  input  wire [7:0]  reg_rdata,         // Read data
  output reg  [15:0] reg_addr  = 16'h0000, // Address
  output reg         reg_write = 1'b0,  // Write strobe
  output reg  [7:0]  reg_wdata = 8'h00  // Write data
);
  // reserved ranges avoided, callers pass only mapped or unlisted addresses
  task wr(input [15:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_write <= 1'b1;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read data is registered, so it is taken one edge after the address
  task rd(input [15:0] a, output [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule // audio_host_model

/* File: test/tb_audio_control_volume_regs.sv */
// Self-checking bench for the audio control bank
`timescale 1ns/10ps
module tb_audio_control_volume_regs;
  reg         mclk = 1'b0;
  reg         resetn = 1'b0;
  wire [15:0] reg_addr;
  wire        reg_write;
  wire [7:0]  reg_wdata;
  wire [7:0]  reg_rdata;
  wire        subsystem_reset, audio_power_on, digital_path_off, amp_digital_off;
  wire [6:0]  dac0_left_atten;
  wire        dac0_left_mute;
  wire [6:0]  dac0r_atten, dac1l_atten, dac1r_atten;
  wire        dac0r_mute, dac1l_mute, dac1r_mute, mixl_mute, mixr_mute, gainl_mute, gainr_mute;
  wire [4:0]  mixl_atten, mixr_atten, gainl, gainr;
  reg  [39:0] rows [0:9];
  reg  [7:0]  got;
  integer     i, n, bad_count = 0, total_checks = 0, cyc = 0;
  always #20 mclk = ~mclk;
  audio_host_model host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata));
  audio_control_volume_regs uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .subsystem_reset(subsystem_reset), .audio_power_on(audio_power_on),
    .digital_path_off(digital_path_off), .amp_digital_off(amp_digital_off), .dac0_left_atten(dac0_left_atten),
    .dac0_left_mute(dac0_left_mute), .dac0_right_atten(dac0r_atten), .dac0_right_mute(dac0r_mute),
    .dac1_left_atten(dac1l_atten), .dac1_left_mute(dac1l_mute), .dac1_right_atten(dac1r_atten),
    .dac1_right_mute(dac1r_mute), .mix_left_atten(mixl_atten), .mix_left_mute(mixl_mute),
    .mix_right_atten(mixr_atten), .mix_right_mute(mixr_mute), .primary_left_mixer_gain(gainl),
    .primary_left_mixer_mute(gainl_mute), .primary_right_mixer_gain(gainr), .primary_right_mixer_mute(gainr_mute));
  task chk(input [7:0] g, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // A hang counts as a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    // Rows: address, written value, reset value, readback
    rows[0] = {16'hA1A0, 8'h7F, 8'h80, 8'h7F};
    rows[1] = {16'hA1A1, 8'h55, 8'h80, 8'h55};
    rows[2] = {16'hA1A2, 8'h80, 8'h80, 8'h80};
    rows[3] = {16'hA1A3, 8'h2A, 8'h80, 8'h2A};
    rows[4] = {16'hA1A6, 8'hFF, 8'h80, 8'hFF};
    rows[5] = {16'hA1A7, 8'h1F, 8'h80, 8'h1F};
    rows[6] = {16'hA1A8, 8'h9F, 8'h8C, 8'h9F};
    rows[7] = {16'hA1A9, 8'h00, 8'h8C, 8'h00};
    rows[8] = {16'hA038, 8'hF6, 8'h00, 8'hF6};
    rows[9] = {16'hA039, 8'hAA, 8'h00, 8'h00};
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      host.rd(rows[i][39:24], got);
      chk(got, rows[i][15:8]);
    end
    chk({gainr_mute, 2'b00, gainr}, 8'h8C);
    chk({mixr_mute, 2'b00, mixr_atten}, 8'h80);
    chk({dac1r_mute, dac1r_atten}, 8'h80);
    for (i = 0; i < 10; i = i + 1) begin
      host.wr(rows[i][39:24], rows[i][23:16]);
      host.rd(rows[i][39:24], got);
      chk(got, rows[i][7:0]);
    end
    chk({5'h00, amp_digital_off, digital_path_off, audio_power_on}, 8'h03);
    chk({1'b0, dac0_left_atten}, 8'h7F);
    chk({dac0r_mute, dac0r_atten}, 8'h55);
    chk({dac1l_mute, dac1l_atten}, 8'h80);
    chk({dac1r_mute, dac1r_atten}, 8'h2A);
    chk({mixl_mute, 2'b00, mixl_atten}, 8'h9F);
    chk({mixr_mute, 2'b00, mixr_atten}, 8'h1F);
    chk({gainl_mute, 2'b00, gainl}, 8'h9F);
    chk({gainr_mute, 2'b00, gainr}, 8'h00);
    host.wr(16'hA038, 8'h03);
    n = 0;
    repeat (10) begin
      #1 if (subsystem_reset === 1'b1) n = n + 1;
      @(posedge mclk);
    end
    chk(n[7:0], 8'h07);
    host.rd(16'hA038, got);
    chk(got, 8'h02);
    host.wr(16'hA038, 8'h00);
    #1 chk({7'h00, subsystem_reset | audio_power_on}, 8'h00);
    resetn <= 1'b0;
    @(posedge mclk);
    #1 chk({dac0_left_mute, dac0_left_atten}, 8'h80);
    chk({gainl_mute, 2'b00, gainl}, 8'h8C);
    @(posedge mclk);
    resetn <= 1'b1;
    host.rd(16'hA1A6, got);
    chk(got, 8'h80);
    host.wr(16'hA038, 8'h01);
    #1 chk({7'h00, subsystem_reset}, 8'h01);
    tally_and_finish;
  end
endmodule // tb_audio_control_volume_regs
